// *** faw_cam.sv ***
// Camera model driving frame, line and data enables with pixel data
`timescale 1ns/1ps
module faw_cam #(
   parameter int NL = 5,
   parameter int NP = 8,
   parameter int GAP = 3
)(
   input wire logic link_clk,
   output faw_pkg::faw_video_t vid
);
   initial vid = '0;
   // Data toggles when not valid so a stale value never looks like a pixel
   task automatic step(input logic f, input logic l, input logic d, input logic [23:0] x);
      @(posedge link_clk);
      vid <= '{f, l, d, d ? x : ~vid.data};
   endtask
   task automatic send_frame(input logic [7:0] id);
      int p;
      repeat (8) step(1'h0, 1'h0, 1'h0, 24'h0);
      for (int l = 0; l < NL; l++)
      begin
         p = 0;
         step(1'h1, 1'h0, 1'h0, 24'h0);
         for (int c = 0; c <= NP; c++)
         begin
            step(1'h1, 1'h1, c != GAP, {id, 8'(l), 8'(p)});
            if (c != GAP)
               p++;
         end
         step(1'h1, 1'h0, 1'h0, 24'h0);
      end
      repeat (3) step(1'h0, 1'h0, 1'h0, 24'h0);
   endtask
endmodule

// *** faw_pkg.sv ***
// Package with shared constants and types for the frame acquisition window block
package faw_pkg;
   localparam int PIX_W = 24;
   localparam int CNT_W = 16;
   localparam int NTRIG_EXT = 4;
   localparam int NTRIG_SYS = 7;
   localparam int NTRIG = NTRIG_EXT + NTRIG_SYS;
   localparam int FCNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FRAMES = 8'h04;
   localparam logic [7:0] ADDR_AW_PIX = 8'h08;
   localparam logic [7:0] ADDR_AW_LINE = 8'h0C;
   localparam logic [7:0] ADDR_ROI_PIX = 8'h10;
   localparam logic [7:0] ADDR_ROI_LINE = 8'h14;
   localparam logic [7:0] ADDR_TRIG_EN = 8'h18;
   localparam logic [7:0] ADDR_TRIG_POL = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;

   // CTRL field positions
   localparam int CTRL_SW_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_ISO0 = 2;
   localparam int CTRL_ISO1 = 3;
   localparam int CTRL_ENC_TRIG = 4;
   localparam int CTRL_EXPANSION = 5;
   localparam int CTRL_CONT = 6;
   localparam int HALF = 16;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [CNT_W-1:0] first;
      logic [CNT_W-1:0] count;
   } faw_span_t;

   typedef struct packed {
      faw_span_t aw_pix;
      faw_span_t aw_line;
      faw_span_t roi_pix;
      faw_span_t roi_line;
      logic [FCNT_W-1:0] frames;
      logic cont;
   } faw_cfg_t;

   typedef struct packed {
      logic fval;
      logic lval;
      logic dval;
      logic [PIX_W-1:0] data;
   } faw_video_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } faw_state_t;
endpackage

// *** faw_top.sv ***
// Acquisition window, region of interest and start control with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Only the pixels selected by the windows go on to the tap formatter output.
// - Each line keeps a programmed first pixel and pixel count counted from line enable rising.
// - Each frame keeps a programmed first line and line count counted from frame enable rising.
// - A second nested pixel and line window forms the region of interest inside the acquisition window.
// - Region cropping acts on every line and every frame of an acquisition.
// - With continuous mode off, a software start captures a programmed number of frames and then stops.
// - Any enabled external or system trigger line starts acquisition; disabled lines are ignored.
// - Each trigger input has its own rising or falling edge select.
// - The isolated inputs replace digital trigger lines zero and one, never both at once.
// - The encoder pairs act as encoder input or as trigger inputs two and three instead of the digital lines.
// - With an expansion board attached, only trigger zero stays usable on the auxiliary connector.
module faw_top #(
   parameter int PIX_W = faw_pkg::PIX_W
)(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire faw_pkg::faw_video_t cam_video,
   input wire logic [faw_pkg::NTRIG_EXT-1:0] digital_trigger_line,
   input wire logic [1:0] iso_in,
   input wire logic [1:0] enc_in,
   input wire logic [faw_pkg::NTRIG_SYS-1:0] sys_trig,
   input wire logic expansion_present,
   output logic [faw_pkg::FCNT_W-1:0] enc_position,
   output logic pix_valid,
   output logic [PIX_W-1:0] pix_data,
   output logic pix_sof,
   output logic pix_eol
);
   initial
   begin
      if (PIX_W < 1 || PIX_W > faw_pkg::PIX_W)
         $error("PIX_W out of range");
   end

   localparam int NT = faw_pkg::NTRIG;

   typedef struct packed {
      logic ph_act;
      logic [7:0] ph_addr;
      logic ph_wr;
      faw_pkg::faw_cfg_t cfg;
      logic iso0;
      logic iso1;
      logic enc_trig;
      logic [NT-1:0] trig_en;
      logic [NT-1:0] trig_pol;
      logic [31:0] rdata;
      logic start_tgl;
      logic stop_tgl;
      logic [NT-1:0] tr_s1;
      logic [NT-1:0] tr_s2;
      logic [NT-1:0] tr_s3;
      logic exp_s1;
      logic exp_s2;
      logic busy_s1;
      logic busy_s2;
      logic [1:0] enc_s1;
      logic [1:0] enc_s2;
      logic [1:0] enc_s3;
      logic [faw_pkg::FCNT_W-1:0] enc_pos;
   } top_t;

   top_t s_r;
   top_t s_nxt;
   logic busy_link;
   logic [NT-1:0] trig_raw;

   // Isolated inputs stand in for triggers zero and one
   // Encoder pairs stand in for triggers two and three
   assign trig_raw[0] = s_r.iso0 ? iso_in[0] : digital_trigger_line[0];
   assign trig_raw[1] = s_r.iso1 ? iso_in[1] : digital_trigger_line[1];
   assign trig_raw[2] = s_r.enc_trig ? enc_in[0] : digital_trigger_line[2];
   assign trig_raw[3] = s_r.enc_trig ? enc_in[1] : digital_trigger_line[3];
   assign trig_raw[NT-1:faw_pkg::NTRIG_EXT] = sys_trig;

   always_comb
   begin
      logic [NT-1:0] edge_hit;
      logic [NT-1:0] usable;
      logic [31:0] wd;
      logic do_start;
      logic enc_step;
      s_nxt = s_r;
      wd = hwdata;
      do_start = 1'b0;
      edge_hit = '0;
      usable = '0;
      enc_step = 1'b0;
      s_nxt.tr_s1 = trig_raw;
      s_nxt.tr_s2 = s_r.tr_s1;
      s_nxt.tr_s3 = s_r.tr_s2;
      s_nxt.exp_s1 = expansion_present;
      s_nxt.exp_s2 = s_r.exp_s1;
      s_nxt.busy_s1 = busy_link;
      s_nxt.busy_s2 = s_r.busy_s1;
      // Address phase capture
      if (hready)
      begin
         s_nxt.ph_act = hsel && (htrans == faw_pkg::HTRANS_NONSEQ);
         s_nxt.ph_addr = haddr[7:0];
         s_nxt.ph_wr = hwrite;
      end
      // Data phase write
      if (s_r.ph_act && s_r.ph_wr)
      begin
         unique case (s_r.ph_addr)
            faw_pkg::ADDR_CTRL:
            begin
               if (wd[faw_pkg::CTRL_SW_START])
                  do_start = 1'b1;
               if (wd[faw_pkg::CTRL_STOP])
                  s_nxt.stop_tgl = !s_r.stop_tgl;
               // Never both isolated inputs at once; input one yields
               s_nxt.iso0 = wd[faw_pkg::CTRL_ISO0];
               s_nxt.iso1 = wd[faw_pkg::CTRL_ISO1] && !wd[faw_pkg::CTRL_ISO0];
               s_nxt.enc_trig = wd[faw_pkg::CTRL_ENC_TRIG];
               s_nxt.cfg.cont = wd[faw_pkg::CTRL_CONT];
            end
            faw_pkg::ADDR_FRAMES: s_nxt.cfg.frames = wd[faw_pkg::FCNT_W-1:0];
            faw_pkg::ADDR_AW_PIX: s_nxt.cfg.aw_pix = wd;
            faw_pkg::ADDR_AW_LINE: s_nxt.cfg.aw_line = wd;
            faw_pkg::ADDR_ROI_PIX: s_nxt.cfg.roi_pix = wd;
            faw_pkg::ADDR_ROI_LINE: s_nxt.cfg.roi_line = wd;
            faw_pkg::ADDR_TRIG_EN: s_nxt.trig_en = wd[NT-1:0];
            faw_pkg::ADDR_TRIG_POL: s_nxt.trig_pol = wd[NT-1:0];
            default: ;
         endcase
      end
      // Expansion board leaves only external trigger zero; system triggers stay usable
      usable = {{faw_pkg::NTRIG_SYS{1'b1}}, {(faw_pkg::NTRIG_EXT-1){!s_r.exp_s2}}, 1'b1};
      // Per-input edge select, pol 1 means falling
      edge_hit = (s_r.trig_pol & s_r.tr_s3 & ~s_r.tr_s2) | (~s_r.trig_pol & ~s_r.tr_s3 & s_r.tr_s2);
      if (|(edge_hit & s_r.trig_en & usable) && !s_r.busy_s2)
         do_start = 1'b1;
      if (do_start)
         s_nxt.start_tgl = !s_r.start_tgl;
      // Quadrature count when pairs are not triggers and no expansion board is present
      // Encoder phases get their own synchroniser; the trigger path only sees them in trigger mode
      s_nxt.enc_s1 = enc_in;
      s_nxt.enc_s2 = s_r.enc_s1;
      s_nxt.enc_s3 = s_r.enc_s2;
      enc_step = !s_r.enc_trig && !s_r.exp_s2 && (s_r.enc_s2[0] != s_r.enc_s3[0]);
      if (enc_step)
      begin
         if (s_r.enc_s2[0] ^ s_r.enc_s2[1])
            s_nxt.enc_pos = s_r.enc_pos + 1'b1;
         else
            s_nxt.enc_pos = s_r.enc_pos - 1'b1;
      end
      // Read data, unmapped reads zero
      s_nxt.rdata = '0;
      if (hready && hsel && (htrans == faw_pkg::HTRANS_NONSEQ) && !hwrite)
      begin
         unique case (haddr[7:0])
            faw_pkg::ADDR_CTRL:
            begin
               s_nxt.rdata[faw_pkg::CTRL_ISO0] = s_r.iso0;
               s_nxt.rdata[faw_pkg::CTRL_ISO1] = s_r.iso1;
               s_nxt.rdata[faw_pkg::CTRL_ENC_TRIG] = s_r.enc_trig;
               s_nxt.rdata[faw_pkg::CTRL_EXPANSION] = s_r.exp_s2;
               s_nxt.rdata[faw_pkg::CTRL_CONT] = s_r.cfg.cont;
            end
            faw_pkg::ADDR_FRAMES: s_nxt.rdata[faw_pkg::FCNT_W-1:0] = s_r.cfg.frames;
            faw_pkg::ADDR_AW_PIX: s_nxt.rdata = s_r.cfg.aw_pix;
            faw_pkg::ADDR_AW_LINE: s_nxt.rdata = s_r.cfg.aw_line;
            faw_pkg::ADDR_ROI_PIX: s_nxt.rdata = s_r.cfg.roi_pix;
            faw_pkg::ADDR_ROI_LINE: s_nxt.rdata = s_r.cfg.roi_line;
            faw_pkg::ADDR_TRIG_EN: s_nxt.rdata[NT-1:0] = s_r.trig_en;
            faw_pkg::ADDR_TRIG_POL: s_nxt.rdata[NT-1:0] = s_r.trig_pol;
            faw_pkg::ADDR_STATUS:
            begin
               s_nxt.rdata[0] = s_r.busy_s2;
               s_nxt.rdata[faw_pkg::HALF +: faw_pkg::FCNT_W] = s_r.enc_pos;
            end
            default: ;
         endcase
      end
      if (!nrst)
      begin
         s_nxt = '0;
         s_nxt.cfg.frames = {{(faw_pkg::FCNT_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge sys_clk)
      s_r <= s_nxt;

   // Config is quasi-static: software changes it only while idle
   faw_window #(.PIX_W(PIX_W)) u_win (
      .link_clk(link_clk),
      .link_nrst(link_nrst),
      .vid(cam_video),
      .cfg(s_r.cfg),
      .start_tgl(s_r.start_tgl),
      .stop_tgl(s_r.stop_tgl),
      .busy(busy_link),
      .pix_valid(pix_valid),
      .pix_data(pix_data),
      .pix_sof(pix_sof),
      .pix_eol(pix_eol)
   );

   assign hrdata = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign enc_position = s_r.enc_pos;
endmodule

// *** faw_top_checker.sv ***
// Assertion checker for the frame acquisition window block
`timescale 1ns/1ps
module faw_top_checker #(
   parameter int PIX_W = 24
)(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire faw_pkg::faw_video_t cam_video,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic pix_sof,
   input wire logic pix_eol
);
   logic beat;
   assign beat = cam_video.fval && cam_video.lval && cam_video.dval;
   // Two idle data cycles in a row
   sequence idle2_s;
      !cam_video.dval ##1 !cam_video.dval;
   endsequence
   bus_always_ready_a:
      assert property (@(posedge sys_clk) disable iff (!nrst) hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   valid_needs_beat_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_valid |-> $past(beat))
      else $error("pixel out without a camera beat");
   data_follows_beat_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_valid |-> pix_data == $past(cam_video.data))
      else $error("pixel data differs from camera data");
   idle_gives_nothing_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) idle2_s |=> !pix_valid)
      else $error("pixel out after idle data cycles");
   sof_with_valid_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_sof |-> pix_valid && $past(cam_video.fval))
      else $error("frame start marker without pixel in frame");
   eol_single_pulse_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_eol |=> !pix_eol)
      else $error("line end marker longer than one cycle");
   eol_after_fall_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_eol |-> !$past(cam_video.lval))
      else $error("line end marker while line enable high");
   eol_no_pixel_a:
      assert property (@(posedge link_clk) disable iff (!link_nrst) pix_eol |-> !$past(cam_video.dval))
      else $error("line end marker beside a pixel beat");
endmodule
bind faw_top faw_top_checker #(.PIX_W(PIX_W)) faw_top_checker_i (.sys_clk(sys_clk), .nrst(nrst),
   .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .link_nrst(link_nrst), .cam_video(cam_video),
   .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol));

// *** faw_window.sv ***
// Link-clock pixel windowing and frame counting
`timescale 1ns/1ps
module faw_window #(
   parameter int PIX_W = faw_pkg::PIX_W
)(
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire faw_pkg::faw_video_t vid,
   input wire faw_pkg::faw_cfg_t cfg,
   input wire logic start_tgl,
   input wire logic stop_tgl,
   output logic busy,
   output logic pix_valid,
   output logic [PIX_W-1:0] pix_data,
   output logic pix_sof,
   output logic pix_eol
);
   typedef struct packed {
      faw_pkg::faw_video_t prev;
      logic start_s1;
      logic start_s2;
      logic start_s3;
      logic stop_s1;
      logic stop_s2;
      logic stop_s3;
      faw_pkg::faw_state_t state;
      logic [faw_pkg::CNT_W-1:0] pcnt;
      logic [faw_pkg::CNT_W-1:0] lcnt;
      logic [faw_pkg::FCNT_W-1:0] fdone;
      logic first_pix;
      logic valid;
      logic [PIX_W-1:0] data;
      logic sof;
      logic eol;
   } win_t;

   win_t s_r;
   win_t s_nxt;

   function automatic logic in_span(input logic [faw_pkg::CNT_W-1:0] idx, input faw_pkg::faw_span_t sp);
      in_span = (idx >= sp.first) && ({1'b0, idx} < ({1'b0, sp.first} + {1'b0, sp.count}));
   endfunction

   always_comb
   begin
      logic fr_rise;
      logic fr_fall;
      logic ln_rise;
      logic keep;
      logic start_ev;
      logic stop_ev;
      keep = 1'b0;
      s_nxt = s_r;
      s_nxt.prev = vid;
      s_nxt.start_s1 = start_tgl;
      s_nxt.start_s2 = s_r.start_s1;
      s_nxt.start_s3 = s_r.start_s2;
      s_nxt.stop_s1 = stop_tgl;
      s_nxt.stop_s2 = s_r.stop_s1;
      s_nxt.stop_s3 = s_r.stop_s2;
      start_ev = s_r.start_s2 ^ s_r.start_s3;
      stop_ev = s_r.stop_s2 ^ s_r.stop_s3;
      fr_rise = vid.fval && !s_r.prev.fval;
      fr_fall = !vid.fval && s_r.prev.fval;
      ln_rise = vid.lval && !s_r.prev.lval;
      s_nxt.valid = 1'b0;
      s_nxt.sof = 1'b0;
      s_nxt.eol = 1'b0;
      if (ln_rise)
         s_nxt.pcnt = '0;
      if (fr_rise)
      begin
         s_nxt.lcnt = '0;
         s_nxt.first_pix = 1'b1;
      end
      else if (!vid.lval && s_r.prev.lval && vid.fval)
         s_nxt.lcnt = s_r.lcnt + 1'b1;
      unique case (s_r.state)
         faw_pkg::ST_IDLE:
         begin
            if (start_ev)
            begin
               s_nxt.state = faw_pkg::ST_WAIT;
               s_nxt.fdone = '0;
            end
         end
         faw_pkg::ST_WAIT:
         begin
            // Waits for a fresh frame so no partial frame is captured
            if (stop_ev)
               s_nxt.state = faw_pkg::ST_IDLE;
            else if (fr_rise)
               s_nxt.state = faw_pkg::ST_RUN;
         end
         faw_pkg::ST_RUN:
         begin
            if (vid.fval && vid.lval && vid.dval)
            begin
               s_nxt.pcnt = (ln_rise ? '0 : s_r.pcnt) + 1'b1;
               // Applied on every line and frame
               keep = in_span(ln_rise ? '0 : s_r.pcnt, cfg.aw_pix) && in_span(s_nxt.lcnt, cfg.aw_line)
                  && in_span(ln_rise ? '0 : s_r.pcnt, cfg.roi_pix) && in_span(s_nxt.lcnt, cfg.roi_line);
               if (keep)
               begin
                  s_nxt.valid = 1'b1;
                  s_nxt.data = vid.data;
                  s_nxt.sof = s_nxt.first_pix;
                  s_nxt.first_pix = 1'b0;
               end
            end
            if (!vid.lval && s_r.prev.lval)
               s_nxt.eol = 1'b1;
            if (fr_fall)
            begin
               s_nxt.fdone = s_r.fdone + 1'b1;
               if (stop_ev || (!cfg.cont && (s_r.fdone + 1'b1 >= cfg.frames)))
                  s_nxt.state = faw_pkg::ST_IDLE;
               else
                  s_nxt.state = faw_pkg::ST_WAIT;
            end
         end
         default:
            s_nxt.state = faw_pkg::ST_IDLE;
      endcase
      if (!link_nrst)
         s_nxt = '0;
   end

   always_ff @(posedge link_clk)
      s_r <= s_nxt;

   assign busy = (s_r.state != faw_pkg::ST_IDLE);
   assign pix_valid = s_r.valid;
   assign pix_data = s_r.data;
   assign pix_sof = s_r.sof;
   assign pix_eol = s_r.eol;
endmodule

// *** tb_frame_acq_window_roi_start.sv ***
// Self-checking testbench for the frame acquisition window block
`timescale 1ns/1ps
module tb_frame_acq_window_roi_start;
   typedef struct packed {
      logic [7:0] ctrl;
      logic ex;
      logic [10:0] en;
      logic [10:0] pol;
      logic [3:0] src;
      logic st;
   } faw_tcase_t;
   localparam faw_tcase_t TC[9] = '{'{8'h00, 1'h0, 11'h002, 11'h000, 4'h1, 1'h1},
      '{8'h00, 1'h0, 11'h002, 11'h000, 4'h2, 1'h0}, '{8'h00, 1'h0, 11'h010, 11'h010, 4'h8, 1'h1},
      '{8'h04, 1'h0, 11'h001, 11'h000, 4'h0, 1'h0}, '{8'h04, 1'h0, 11'h001, 11'h000, 4'h4, 1'h1},
      '{8'h10, 1'h0, 11'h004, 11'h004, 4'h6, 1'h1}, '{8'h10, 1'h0, 11'h004, 11'h000, 4'h2, 1'h0},
      '{8'h00, 1'h1, 11'h002, 11'h000, 4'h1, 1'h0}, '{8'h00, 1'h1, 11'h001, 11'h000, 4'h0, 1'h1}};
   // ROI spans chosen so nested and absolute readings agree
   localparam logic [31:0] WIN[2][4] = '{'{32'h0000_0008, 32'h0000_0005, 32'h0002_0003, 32'h0001_0002},
      '{32'h0003_0004, 32'h0001_0003, 32'h0000_FFFF, 32'h0000_FFFF}};
   localparam int EXW[2][5] = '{'{2, 2, 3, 1, 2}, '{1, 3, 4, 1, 3}};
   // Encoder phases {B, A}: one cycle forward, then one cycle back to the start count
   localparam logic [1:0] QS[8] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b10, 2'b11, 2'b01, 2'b00};
   logic sys_clk, nrst, link_clk, link_nrst, hwrite, expansion_present, hreadyout, hresp;
   logic pix_valid, pix_sof, pix_eol;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [faw_pkg::PIX_W-1:0] pix_data;
   logic [14:0] tv;
   logic [15:0] enc_pos;
   faw_pkg::faw_video_t cam_video;
   logic [23:0] got[$];
   int err_total, num_checks, sof_n, eol_n;
   faw_cam faw_cam_i (.link_clk(link_clk), .vid(cam_video));
   faw_top faw_top_i (.sys_clk(sys_clk), .nrst(nrst), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .link_nrst(link_nrst),
      .cam_video(cam_video), .digital_trigger_line(tv[3:0]), .iso_in(tv[5:4]), .enc_in(tv[7:6]),
      .sys_trig(tv[14:8]), .expansion_present(expansion_present), .enc_position(enc_pos), .pix_valid(pix_valid),
      .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol));
   initial
   begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial
   begin
      link_clk = 1'h0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   always @(posedge link_clk)
   begin
      if (pix_valid === 1'h1)
         got.push_back(pix_data);
      if (pix_sof === 1'h1)
         sof_n++;
      if (pix_eol === 1'h1)
         eol_n++;
   end
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      num_checks++;
      if (got_v !== exp_v)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One bus phase; ends at the rising edge where hready is high, read data taken at that edge
   task automatic phase(output logic [31:0] d);
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         d = hrdata;
         n++;
      end
      while (hreadyout !== 1'h1 && n < 50);
      if (hreadyout !== 1'h1)
      begin
         err_total++;
         wrap_up();
      end
   endtask
   task automatic bus(input logic wr_v, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd_v);
      logic [31:0] dummy;
      htrans <= faw_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr_v;
      phase(dummy);
      htrans <= 2'h0;
      hwdata <= wd;
      phase(rd_v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d, rd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'h0, a, 32'h0, rd);
      chk(rd & m, e);
   endtask
   task automatic pix_chk(input int fr, input int pf, input int pn, input int lf, input int ln);
      int i;
      i = 0;
      chk(32'(got.size()), 32'(fr * pn * ln));
      chk(32'(sof_n), 32'(fr));
      chk(32'(eol_n), 32'(fr * faw_cam_i.NL));
      for (int f = 0; f < fr; f++)
         for (int l = lf; l < lf + ln; l++)
            for (int p = pf; p < pf + pn; p++)
            begin
               if (i < got.size())
                  chk({8'h0, got[i]}, {8'h0, 8'(f), 8'(l), 8'(p)});
               i++;
            end
      got.delete();
      sof_n = 0;
      eol_n = 0;
   endtask
   initial
   begin
      nrst = 1'h0;
      link_nrst = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      tv = 15'h0;
      expansion_present = 1'h0;
      err_total = 0;
      num_checks = 0;
      sof_n = 0;
      eol_n = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'h1;
      link_nrst <= 1'h1;
      @(posedge sys_clk);
      rdc(faw_pkg::ADDR_FRAMES, 32'hFFFF_FFFF, 32'h1);
      wr(8'h40, 32'hFFFF_FFFF);
      rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
      wr(faw_pkg::ADDR_AW_PIX, 32'h1234_5678);
      rdc(faw_pkg::ADDR_AW_PIX, 32'hFFFF_FFFF, 32'h1234_5678);
      wr(faw_pkg::ADDR_CTRL, 32'h0000_000C);
      rdc(faw_pkg::ADDR_CTRL, 32'h0000_000C, 32'h4);
      for (int k = 0; k < 2; k++)
      begin
         for (int j = 0; j < 4; j++)
            wr(8'h08 + 8'(4 * j), WIN[k][j]);
         wr(faw_pkg::ADDR_FRAMES, 32'(EXW[k][0]));
         wr(faw_pkg::ADDR_CTRL, 32'h1);
         for (int f = 0; f < 3; f++)
            faw_cam_i.send_frame(8'(f));
         @(posedge sys_clk);
         pix_chk(EXW[k][0], EXW[k][1], EXW[k][2], EXW[k][3], EXW[k][4]);
         rdc(faw_pkg::ADDR_STATUS, 32'h1, 32'h0);
      end
      // Continuous mode keeps waiting after a frame until a stop
      wr(faw_pkg::ADDR_CTRL, 32'h0000_0041);
      faw_cam_i.send_frame(8'h0);
      @(posedge sys_clk);
      pix_chk(1, 3, 4, 1, 3);
      rdc(faw_pkg::ADDR_STATUS, 32'h1, 32'h1);
      wr(faw_pkg::ADDR_CTRL, 32'h0000_0002);
      repeat (12) @(posedge sys_clk);
      rdc(faw_pkg::ADDR_STATUS, 32'h1, 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         expansion_present <= TC[k].ex;
         wr(faw_pkg::ADDR_CTRL, {24'h0, TC[k].ctrl});
         wr(faw_pkg::ADDR_TRIG_EN, {21'h0, TC[k].en});
         wr(faw_pkg::ADDR_TRIG_POL, {21'h0, TC[k].pol});
         tv[TC[k].src] <= 1'h1;
         repeat (20) @(posedge sys_clk);
         rdc(faw_pkg::ADDR_STATUS, 32'h1, {31'h0, TC[k].st & ~|TC[k].pol});
         tv[TC[k].src] <= 1'h0;
         repeat (20) @(posedge sys_clk);
         rdc(faw_pkg::ADDR_STATUS, 32'h1, {31'h0, TC[k].st});
         faw_cam_i.send_frame(8'h0);
         @(posedge sys_clk);
         pix_chk(int'(TC[k].st), 3, 4, 1, 3);
      end
      expansion_present <= 1'h0;
      wr(faw_pkg::ADDR_CTRL, 32'h0);
      for (int q = 0; q < 8; q++)
      begin
         tv[7:6] <= QS[q];
         repeat (6) @(posedge sys_clk);
         if (q == 3)
         begin
            chk(32'(enc_pos != 16'h0), 32'h1);
            bus(1'h0, faw_pkg::ADDR_STATUS, 32'h0, rd);
            chk(32'(rd[31:16] != 16'h0), 32'h1);
         end
      end
      chk({16'h0, enc_pos}, 32'h0);
      rdc(faw_pkg::ADDR_STATUS, 32'hFFFF_0000, 32'h0);
      wrap_up();
   end
endmodule
